// *** rtl/product_quotient_pkg.sv ***
// Shared types and constants for the integer multiply/divide unit
package product_quotient_pkg;

   localparam int WORD_W = 32;
   localparam int HALF_W = 16;
   localparam int REG_ADDR_W = 5;
   localparam int REG_COUNT = 32;
   localparam int DIV_CNT_W = 6;

   // Iterations skipped by the early-in check, per dividend width class
   localparam logic [DIV_CNT_W-1:0] DIV_SKIP_8 = 6'h17;
   localparam logic [DIV_CNT_W-1:0] DIV_SKIP_16 = 6'h0f;
   localparam logic [DIV_CNT_W-1:0] DIV_SKIP_24 = 6'h07;
   localparam logic [DIV_CNT_W-1:0] DIV_SKIP_32 = 6'h00;
   localparam logic [DIV_CNT_W-1:0] DIV_ITER_FULL = 6'h20;

   // Divide latency in clocks; the repeat rate is one less
   localparam logic [DIV_CNT_W-1:0] DIV_LAT_8 = 6'h0c;
   localparam logic [DIV_CNT_W-1:0] DIV_LAT_16 = 6'h13;
   localparam logic [DIV_CNT_W-1:0] DIV_LAT_24 = 6'h1a;
   localparam logic [DIV_CNT_W-1:0] DIV_LAT_32 = 6'h21;

   localparam logic [WORD_W-1:0] RESULT_RESET = 32'h0000_0000;
   localparam logic [REG_ADDR_W-1:0] ZERO_REG = 5'h00;

   typedef enum logic [3:0] {
      signed_product_op,
      unsigned_product_op,
      signed_accumulate_op,
      unsigned_accumulate_op,
      signed_deduct_op,
      unsigned_deduct_op,
      signed_quotient_op,
      unsigned_quotient_op,
      read_upper_word_op,
      read_bottom_word_op,
      register_product_op
   } unit_op_e;

   typedef struct packed {
      logic valid;
      unit_op_e op;
      logic [WORD_W-1:0] operand_a;
      logic [WORD_W-1:0] operand_b;
      logic [REG_ADDR_W-1:0] dest;
   } issue_s;

   typedef struct packed {
      logic en;
      logic [REG_ADDR_W-1:0] addr;
      logic [WORD_W-1:0] data;
   } reg_write_s;

endpackage

// *** rtl/product_quotient_unit.sv ***
// Multiply/divide unit with its result pair and the general register file
//
// Functional notes
// - Own pipeline keeps running despite integer stalls.
// - Booth 32x16 array; second operand decides passes.
// - Short second operand one pass; full two.
// - Short multiply every clock; full every other.
// - Operand size detected internally, no size input.
// - Divide iterates one quotient bit per clock.
// - Early-in skips 23, 15, 7 iterations.
// - Divide stalls pair ops until done, register multiply until its last cycle.
// - Result-pair multiplies: latency/repeat 1/1, 2/2.
// - Register multiply: latency/repeat 2/1, 3/2.
// - Divide latency/repeat 12/11 to 33/32.
// - Divide and pair-multiply results into pair; moves copy to registers.
// - Register multiply writes low product word.
// - Accumulate adds product to result pair.
// - Deduct subtracts product from result pair.
// - 32x32 register file, two reads, bypassed.
`timescale 1ns/100ps
`default_nettype none
module product_quotient_unit
   import product_quotient_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire issue_s issue,
   output logic issue_hold_r,
   output logic result_hold_r,
   input wire logic [REG_ADDR_W-1:0] read_addr_a,
   input wire logic [REG_ADDR_W-1:0] read_addr_b,
   output logic [WORD_W-1:0] read_data_a_r,
   output logic [WORD_W-1:0] read_data_b_r,
   input wire reg_write_s pipe_write,
   output logic write_port_busy_r,
   output logic [WORD_W-1:0] product_upper_word_r,
   output logic [WORD_W-1:0] result_bottom_word_r,
   output logic div_active_r
);
   function automatic logic op_signed(input unit_op_e op);
      return (op == signed_product_op) || (op == signed_accumulate_op) ||
         (op == signed_deduct_op) || (op == signed_quotient_op) ||
         (op == register_product_op);
   endfunction
   function automatic logic op_is_mul(input unit_op_e op);
      return (op == signed_product_op) || (op == unsigned_product_op) ||
         (op == signed_accumulate_op) || (op == unsigned_accumulate_op) ||
         (op == signed_deduct_op) || (op == unsigned_deduct_op) ||
         (op == register_product_op);
   endfunction
   function automatic logic op_is_div(input unit_op_e op);
      return (op == signed_quotient_op) || (op == unsigned_quotient_op);
   endfunction
   function automatic logic op_is_move(input unit_op_e op);
      return (op == read_upper_word_op) || (op == read_bottom_word_op);
   endfunction
   // Everything but the register-targeted multiply reads or writes the pair
   function automatic logic op_uses_pair(input unit_op_e op);
      return op != register_product_op;
   endfunction
   // Radix-4 Booth pass: 33-bit extended multiplicand times 17-bit signed slice
   function automatic logic [63:0] booth_pass(input logic [32:0] a_ext,
                                              input logic [16:0] b_ext);
      logic [18:0] bx;
      logic [63:0] a64;
      logic [63:0] acc;
      bx = {b_ext[16], b_ext, 1'b0};
      a64 = {{31{a_ext[32]}}, a_ext};
      acc = '0;
      for (int i = 0; i < 9; i++) begin
         case (bx[2*i+2 -: 3])
            3'b001, 3'b010: acc = acc + (a64 << (2*i));
            3'b011: acc = acc + (a64 << (2*i+1));
            3'b100: acc = acc - (a64 << (2*i+1));
            3'b101, 3'b110: acc = acc - (a64 << (2*i));
            default: acc = acc;
         endcase
      end
      return acc;
   endfunction

   // Second operand fits the 16-bit half of the array
   function automatic logic fits_half(input logic [WORD_W-1:0] b, input logic s);
      if (s) begin
         return (&b[31:15]) || !(|b[31:15]);
      end
      return !(|b[31:16]);
   endfunction

   // Early-in class of the dividend: 0 = 8 bits, 1 = 16, 2 = 24, 3 = 32
   function automatic logic [1:0] div_class(input logic [WORD_W-1:0] a, input logic s);
      if (s ? ((&a[31:7]) || !(|a[31:7])) : !(|a[31:7])) begin
         return 2'h0;
      end else if (s ? ((&a[31:15]) || !(|a[31:15])) : !(|a[31:15])) begin
         return 2'h1;
      end else if (s ? ((&a[31:23]) || !(|a[31:23])) : !(|a[31:23])) begin
         return 2'h2;
      end
      return 2'h3;
   endfunction

   function automatic logic [WORD_W-1:0] port_read(input logic [REG_ADDR_W-1:0] addr,
                                                   input logic wen,
                                                   input logic [REG_ADDR_W-1:0] waddr,
                                                   input logic [WORD_W-1:0] wdata,
                                                   input logic [WORD_W-1:0] stored);
      if (addr == ZERO_REG) begin
         return '0;
      end else if (wen && (waddr == addr)) begin
         return wdata;
      end
      return stored;
   endfunction

   // Issue acceptance
   logic take;
   assign take = issue.valid && !issue_hold_r && !(op_uses_pair(issue.op) && result_hold_r);

   // Multiplier: one array, shared by first and second pass
   logic pass2_r;
   unit_op_e mul_op_r;
   logic [REG_ADDR_W-1:0] mul_dest_r;
   logic [32:0] mul_a_r;
   logic [16:0] mul_bup_r;
   logic [63:0] partial_r;
   logic in_signed;
   logic in_short;
   logic [32:0] booth_a;
   logic [16:0] booth_b;
   logic [63:0] booth_out;
   logic [63:0] product;
   logic mul_done;
   unit_op_e done_op;
   logic [REG_ADDR_W-1:0] done_dest;
   assign in_signed = op_signed(issue.op);
   assign in_short = fits_half(issue.operand_b, in_signed);
   assign booth_out = booth_pass(booth_a, booth_b);

   always_comb begin
      if (pass2_r) begin
         booth_a = mul_a_r;
         booth_b = mul_bup_r;
         product = partial_r + (booth_out << HALF_W);
         mul_done = 1'b1;
         done_op = mul_op_r;
         done_dest = mul_dest_r;
      end else begin
         booth_a = {in_signed & issue.operand_a[31], issue.operand_a};
         booth_b = in_short ? {in_signed & issue.operand_b[31], issue.operand_b[15:0]}
            : {1'b0, issue.operand_b[15:0]};
         product = booth_out;
         mul_done = take && op_is_mul(issue.op) && in_short;
         done_op = issue.op;
         done_dest = issue.dest;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pass2_r <= 1'b0;
         mul_op_r <= signed_product_op;
         mul_dest_r <= ZERO_REG;
         mul_a_r <= '0;
         mul_bup_r <= '0;
         partial_r <= '0;
      end else begin
         pass2_r <= take && op_is_mul(issue.op) && !in_short && !pass2_r;
         if (take && op_is_mul(issue.op)) begin
            mul_op_r <= issue.op;
            mul_dest_r <= issue.dest;
            mul_a_r <= booth_a;
            mul_bup_r <= {in_signed & issue.operand_b[31], issue.operand_b[31:16]};
            partial_r <= booth_out;
         end
      end
   end

   // Divider: restoring, one bit per clock on magnitudes
   logic [DIV_CNT_W-1:0] div_cnt_r;
   logic [DIV_CNT_W-1:0] div_last_r;
   logic [DIV_CNT_W-1:0] div_iter_r;
   logic [32:0] rem_r;
   logic [WORD_W-1:0] dvd_r;
   logic [WORD_W-1:0] divisor_r;
   logic neg_quot_r;
   logic neg_rem_r;
   logic [WORD_W-1:0] mag_a;
   logic [WORD_W-1:0] mag_b;
   logic [DIV_CNT_W-1:0] skip;
   logic [DIV_CNT_W-1:0] lat;
   logic [32:0] trial;
   logic [32:0] rem_nxt;
   logic [WORD_W-1:0] dvd_nxt;
   logic div_final;
   logic [WORD_W-1:0] quot_fix;
   logic [WORD_W-1:0] rem_fix;
   assign mag_a = (in_signed && issue.operand_a[31]) ? -issue.operand_a : issue.operand_a;
   assign mag_b = (in_signed && issue.operand_b[31]) ? -issue.operand_b : issue.operand_b;

   always_comb begin
      case (div_class(issue.operand_a, in_signed))
         2'h0: begin
            skip = DIV_SKIP_8;
            lat = DIV_LAT_8;
         end
         2'h1: begin
            skip = DIV_SKIP_16;
            lat = DIV_LAT_16;
         end
         2'h2: begin
            skip = DIV_SKIP_24;
            lat = DIV_LAT_24;
         end
         default: begin
            skip = DIV_SKIP_32;
            lat = DIV_LAT_32;
         end
      endcase
   end

   always_comb begin
      trial = {rem_r[31:0], dvd_r[31]} - {1'b0, divisor_r};
      if (div_iter_r != '0) begin
         if (!trial[32]) begin
            rem_nxt = trial;
         end else begin
            rem_nxt = {rem_r[31:0], dvd_r[31]};
         end
         dvd_nxt = {dvd_r[30:0], !trial[32]};
      end else begin
         rem_nxt = rem_r;
         dvd_nxt = dvd_r;
      end
   end

   // The last iteration may land in the write cycle, so fix up from next values
   assign div_final = div_active_r && (div_cnt_r == div_last_r);
   assign quot_fix = neg_quot_r ? -dvd_nxt : dvd_nxt;
   assign rem_fix = neg_rem_r ? -rem_nxt[31:0] : rem_nxt[31:0];

   // No stall input on purpose: the divide keeps going while the pipe waits
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         div_active_r <= 1'b0;
         div_cnt_r <= '0;
         div_last_r <= '0;
         div_iter_r <= '0;
         rem_r <= '0;
         dvd_r <= '0;
         divisor_r <= '0;
         neg_quot_r <= 1'b0;
         neg_rem_r <= 1'b0;
      end else if (take && op_is_div(issue.op)) begin
         div_active_r <= 1'b1;
         div_cnt_r <= 6'h01;
         div_last_r <= lat - 6'h01;
         div_iter_r <= DIV_ITER_FULL - skip;
         rem_r <= '0;
         dvd_r <= mag_a << skip;
         divisor_r <= mag_b;
         neg_quot_r <= in_signed && (issue.operand_a[31] ^ issue.operand_b[31]);
         neg_rem_r <= in_signed && issue.operand_a[31];
      end else if (div_active_r) begin
         div_cnt_r <= div_cnt_r + 6'h01;
         rem_r <= rem_nxt;
         dvd_r <= dvd_nxt;
         if (div_iter_r != '0) begin
            div_iter_r <= div_iter_r - 6'h01;
         end
         if (div_final) begin
            div_active_r <= 1'b0;
         end
      end
   end

   // Interlocks, one cycle ahead so the outputs stay registered
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         issue_hold_r <= 1'b0;
         result_hold_r <= 1'b0;
      end else if (take && op_is_div(issue.op)) begin
         issue_hold_r <= 1'b1;
         result_hold_r <= 1'b1;
      end else if (div_active_r) begin
         // A full register multiply taken at the divide's tail still needs its bubble
         issue_hold_r <= ((div_cnt_r + 6'h01) < div_last_r) ||
            (take && op_is_mul(issue.op) && !in_short && !pass2_r);
         result_hold_r <= (div_cnt_r + 6'h01) <= div_last_r;
      end else begin
         issue_hold_r <= take && op_is_mul(issue.op) && !in_short && !pass2_r;
         result_hold_r <= 1'b0;
      end
   end

   // Result pair
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         product_upper_word_r <= RESULT_RESET;
         result_bottom_word_r <= RESULT_RESET;
      end else if (div_final) begin
         product_upper_word_r <= rem_fix;
         result_bottom_word_r <= quot_fix;
      end else if (mul_done && op_uses_pair(done_op)) begin
         case (done_op)
            signed_accumulate_op, unsigned_accumulate_op: begin
               {product_upper_word_r, result_bottom_word_r} <=
                  {product_upper_word_r, result_bottom_word_r} + product;
            end
            signed_deduct_op, unsigned_deduct_op: begin
               {product_upper_word_r, result_bottom_word_r} <=
                  {product_upper_word_r, result_bottom_word_r} - product;
            end
            default: begin
               {product_upper_word_r, result_bottom_word_r} <= product;
            end
         endcase
      end
   end

   // Unit write-back stage owning the register write port for one cycle
   logic [REG_ADDR_W-1:0] wb_addr_r;
   logic [WORD_W-1:0] wb_data_r;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         write_port_busy_r <= 1'b0;
         wb_addr_r <= ZERO_REG;
         wb_data_r <= '0;
      end else if (mul_done && (done_op == register_product_op)) begin
         write_port_busy_r <= 1'b1;
         wb_addr_r <= done_dest;
         wb_data_r <= product[WORD_W-1:0];
      end else if (take && op_is_move(issue.op)) begin
         write_port_busy_r <= 1'b1;
         wb_addr_r <= issue.dest;
         wb_data_r <= (issue.op == read_upper_word_op) ? product_upper_word_r
            : result_bottom_word_r;
      end else begin
         write_port_busy_r <= 1'b0;
      end
   end

   // General register file: single write port, unit write-back wins it
   logic [WORD_W-1:0] reg_mem [REG_COUNT];
   logic wen;
   logic [REG_ADDR_W-1:0] waddr;
   logic [WORD_W-1:0] wdata;
   assign wen = write_port_busy_r || pipe_write.en;
   assign waddr = write_port_busy_r ? wb_addr_r : pipe_write.addr;
   assign wdata = write_port_busy_r ? wb_data_r : pipe_write.data;
   always_ff @(posedge core_clk) begin
      if (wen && (waddr != ZERO_REG)) begin
         reg_mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         read_data_a_r <= '0;
         read_data_b_r <= '0;
      end else begin
         read_data_a_r <= port_read(read_addr_a, wen, waddr, wdata, reg_mem[read_addr_a]);
         read_data_b_r <= port_read(read_addr_b, wen, waddr, wdata, reg_mem[read_addr_b]);
      end
   end

endmodule

`default_nettype wire

// *** tb/product_quotient_checker.sv ***
// Port timing checker for the multiply/divide unit
`timescale 1ns/100ps
`default_nettype none
module product_quotient_checker
   import product_quotient_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire issue_s issue,
   input wire logic issue_hold_r,
   input wire logic result_hold_r,
   input wire logic [REG_ADDR_W-1:0] read_addr_a,
   input wire logic [WORD_W-1:0] read_data_a_r,
   input wire logic write_port_busy_r,
   input wire logic [WORD_W-1:0] product_upper_word_r,
   input wire logic [WORD_W-1:0] result_bottom_word_r,
   input wire logic div_active_r
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   logic sgn, short_b, tk, is_div, is_mul, is_reg, is_mov;
   logic [WORD_W-1:0] a, b;
   logic [DIV_CNT_W-1:0] lat, cnt_r, lat_r;
   logic [63:0] sp;
   always_comb begin
      a = issue.operand_a;
      b = issue.operand_b;
      sgn = issue.op inside {signed_product_op, signed_accumulate_op, signed_deduct_op,
         signed_quotient_op, register_product_op};
      short_b = sgn ? (&b[31:15] || ~|b[31:15]) : ~|b[31:16];
      is_div = issue.op inside {signed_quotient_op, unsigned_quotient_op};
      is_mov = issue.op inside {read_upper_word_op, read_bottom_word_op};
      is_mul = issue.op <= unsigned_deduct_op;
      is_reg = issue.op == register_product_op;
      tk = issue.valid && !issue_hold_r && !(!is_reg && result_hold_r);
      sp = {{32{a[31]}}, a} * {{32{b[31]}}, b};
      // Early-in sees only sign extension, so unsigned 128..255 counts as wider
      if ((sgn && &a[31:7]) || ~|a[31:7]) lat = DIV_LAT_8;
      else if ((sgn && &a[31:15]) || ~|a[31:15]) lat = DIV_LAT_16;
      else if ((sgn && &a[31:23]) || ~|a[31:23]) lat = DIV_LAT_24;
      else lat = DIV_LAT_32;
   end
   // Busy cycles of the divider, compared with the class latency less one when it drops
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_r <= '0;
         lat_r <= '0;
      end else if (tk && is_div) begin
         cnt_r <= '0;
         lat_r <= lat;
      end else if (div_active_r) begin
         cnt_r <= cnt_r + 6'h01;
      end
   end
   a_short_mul_rate: assert property (tk && is_mul && short_b |=> !issue_hold_r)
      else $error("short multiply blocked next issue");
   a_full_mul_lock: assert property (tk && is_mul && !short_b |=>
      issue_hold_r ##1 !issue_hold_r)
      else $error("full multiply interlock wrong");
   a_reg_full_lock: assert property (tk && is_reg && !short_b |=> issue_hold_r)
      else $error("full register multiply not interlocked");
   a_short_mul_val: assert property (tk && issue.op == signed_product_op && short_b |=>
      {product_upper_word_r, result_bottom_word_r} == $past(sp))
      else $error("short product wrong or late");
   a_full_mul_val: assert property (tk && issue.op == signed_product_op && !short_b |->
      ##2 {product_upper_word_r, result_bottom_word_r} == $past(sp, 2))
      else $error("full product wrong or late");
   a_reg_mul_short: assert property (tk && is_reg && short_b |=> write_port_busy_r)
      else $error("short register multiply write late");
   a_reg_mul_full: assert property (tk && is_reg && !short_b |=>
      !write_port_busy_r ##1 write_port_busy_r)
      else $error("full register multiply write timing");
   a_div_blocks_issue: assert property (tk && is_div |=>
      div_active_r && issue_hold_r && result_hold_r)
      else $error("divide did not block issue");
   a_div_latency: assert property ($fell(div_active_r) |-> cnt_r == lat_r - 6'h01)
      else $error("divide latency wrong");
   a_div_pair_hold: assert property (div_active_r |-> result_hold_r)
      else $error("pair readable during divide");
   a_move_write: assert property (tk && is_mov |=> write_port_busy_r)
      else $error("move did not write register");
   a_zero_reg: assert property (read_addr_a == ZERO_REG |=>
      read_data_a_r == 32'h0000_0000)
      else $error("register zero not zero");
   c_div: cover property (tk && is_div);
   c_full_mul: cover property (tk && is_mul && !short_b);
   c_reg_full: cover property (tk && is_reg && !short_b);
   c_reg_after_div: cover property (div_active_r && tk && is_reg);
endmodule
`default_nettype wire

// *** tb/pipe_model.sv ***
// Integer pipe model: queues unit operations and issues them in order
`timescale 1ns/100ps
`default_nettype none
module pipe_model
   import product_quotient_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic issue_hold_r,
   input wire logic result_hold_r,
   output var issue_s issue
);
   issue_s q[$];
   logic take;
   assign take = issue.valid && !issue_hold_r && !(issue.op != register_product_op && result_hold_r);
   function automatic logic busy();
      return issue.valid || q.size() != 0;
   endfunction
   task automatic push(input issue_s op);
      q.push_back(op);
   endtask
   // A refused op stays whole until taken; idle fields toggle, not stale
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         issue <= '0;
      end else if (!issue.valid || take) begin
         if (q.size() != 0) begin
            issue <= q.pop_front();
         end else begin
            issue <= issue_s'({1'b0, ~issue[$bits(issue_s)-2:0]});
         end
      end
   end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the multiply/divide unit
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import product_quotient_pkg::*;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [REG_ADDR_W-1:0] read_addr_a = '0;
   logic [REG_ADDR_W-1:0] read_addr_b = '0;
   reg_write_s pipe_write = '0;
   issue_s issue;
   logic issue_hold_r, result_hold_r, write_port_busy_r, div_active_r;
   logic [WORD_W-1:0] read_data_a_r, read_data_b_r, product_upper_word_r, result_bottom_word_r;
   int err_count = 0;
   int checked = 0;
   logic [31:0] seed = 32'h0000_0057;
   logic [63:0] pair = '0;
   always #12.5 core_clk = ~core_clk;
   product_quotient_unit i_product_quotient_unit (.core_clk(core_clk), .reset_n(reset_n),
      .issue(issue), .issue_hold_r(issue_hold_r), .result_hold_r(result_hold_r),
      .read_addr_a(read_addr_a), .read_addr_b(read_addr_b), .read_data_a_r(read_data_a_r),
      .read_data_b_r(read_data_b_r), .pipe_write(pipe_write),
      .write_port_busy_r(write_port_busy_r), .product_upper_word_r(product_upper_word_r),
      .result_bottom_word_r(result_bottom_word_r), .div_active_r(div_active_r));
   pipe_model i_pipe_model (.core_clk(core_clk), .reset_n(reset_n), .issue_hold_r(issue_hold_r),
      .result_hold_r(result_hold_r), .issue(issue));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Random value sign-extended from w bits, so every early-in class is hit
   function automatic logic [31:0] opnd(int w);
      logic [31:0] r;
      r = rnd();
      return 32'($signed(r << (32 - w)) >>> (32 - w));
   endfunction
   function automatic logic [63:0] exp_pair(unit_op_e op, logic [31:0] a, b, logic [63:0] cur);
      logic [63:0] sp, up;
      sp = {{32{a[31]}}, a} * {{32{b[31]}}, b};
      up = {32'h0000_0000, a} * {32'h0000_0000, b};
      case (op)
         signed_product_op: return sp;
         unsigned_product_op: return up;
         signed_accumulate_op: return cur + sp;
         unsigned_accumulate_op: return cur + up;
         signed_deduct_op: return cur - sp;
         unsigned_deduct_op: return cur - up;
         signed_quotient_op: return {32'($signed(a) % $signed(b)), 32'($signed(a) / $signed(b))};
         default: return {a % b, a / b};
      endcase
   endfunction
   task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic results();
      if (err_count == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic go(unit_op_e op, logic [31:0] a, logic [31:0] b, logic [4:0] d);
      if (op <= unsigned_quotient_op) pair = exp_pair(op, a, b, pair);
      i_pipe_model.push('{1'b1, op, a, b, d});
   endtask
   task automatic settle();
      int n;
      n = 0;
      while ((i_pipe_model.busy() || div_active_r) && n < 200) begin
         @(posedge core_clk);
         n++;
      end
      check("settle cycles", n >= 200, 0);
      repeat (4) @(posedge core_clk);
   endtask
   task automatic rd(logic [4:0] ad, output logic [31:0] v);
      @(posedge core_clk);
      read_addr_a <= ad;
      read_addr_b <= ad;
      @(posedge core_clk);
      #1;
      v = read_data_a_r;
      check("read port b", read_data_b_r, v);
   endtask
   initial begin
      logic [31:0] a, b, va;
      logic [4:0] d;
      unit_op_e op;
      int w[4];
      int n;
      w = '{8, 16, 24, 32};
      repeat (5) @(posedge core_clk);
      reset_n <= 1'b1;
      a = rnd();
      @(posedge core_clk);
      pipe_write <= '{1'b1, 5'h05, a};
      @(posedge core_clk);
      pipe_write <= '{1'b1, ZERO_REG, a};
      @(posedge core_clk);
      pipe_write <= '0;
      rd(5'h05, va);
      check("pipe write", va, a);
      rd(ZERO_REG, va);
      check("register zero", va, 32'h0000_0000);
      // Extremes: full by full, then divides at the class edges
      go(unsigned_product_op, 32'hffff_ffff, 32'hffff_ffff, 5'h00);
      go(signed_accumulate_op, 32'h8000_0000, 32'h8000_0000, 5'h00);
      go(signed_quotient_op, 32'hffff_ff80, 32'h0000_0007, 5'h00);
      go(unsigned_quotient_op, 32'h0000_ffff, 32'h0000_0010, 5'h00);
      for (int i = 0; i < 80; i++) begin
         n = int'(rnd() % 3);
         for (int k = 0; k <= n; k++) begin
            op = unit_op_e'(rnd() % 8);
            a = opnd(w[rnd() % 4]);
            b = opnd(w[rnd() % 4]);
            if (b == 32'h0000_0000) b = 32'h0000_0003;
            if (a == 32'h8000_0000 && b == 32'hffff_ffff) b = 32'h0000_0001;
            go(op, a, b, 5'h00);
         end
         d = 5'(rnd() % 29 + 1);
         a = opnd(w[rnd() % 4]);
         b = opnd(w[rnd() % 4]);
         go(register_product_op, a, b, d);
         go(read_upper_word_op, rnd(), rnd(), 5'h1f);
         go(read_bottom_word_op, rnd(), rnd(), 5'h1e);
         settle();
         check("result pair", {product_upper_word_r, result_bottom_word_r}, pair);
         rd(d, va);
         check("register product", va, 32'(a * b));
         rd(5'h1f, va);
         check("upper move", va, pair[63:32]);
         rd(5'h1e, va);
         check("bottom move", va, pair[31:0]);
      end
      results();
   end
   initial begin
      repeat (40000) @(posedge core_clk);
      err_count++;
      results();
   end
endmodule
bind product_quotient_unit product_quotient_checker i_product_quotient_checker (
   .core_clk(core_clk), .reset_n(reset_n), .issue(issue), .issue_hold_r(issue_hold_r),
   .result_hold_r(result_hold_r), .read_addr_a(read_addr_a), .read_data_a_r(read_data_a_r),
   .write_port_busy_r(write_port_busy_r), .product_upper_word_r(product_upper_word_r),
   .result_bottom_word_r(result_bottom_word_r), .div_active_r(div_active_r));
`default_nettype wire
